// ### usbg_map.svh
`ifndef USBG_MAP_SVH
`define USBG_MAP_SVH
// Register offsets on the register port
`define USBG_OFS_RXBUF   16'hFF92
`define USBG_OFS_ERR     16'hFF93
`define USBG_OFS_TXBUF   16'hFF94
`define USBG_OFS_TXSTAT  16'hFF95
`define USBG_OFS_CKSEL   16'hFF96
`define USBG_OFS_DIV     16'hFF97
// Field positions
`define USBG_BIT_PE      2
`define USBG_BIT_FE      1
`define USBG_BIT_OVE     0
`define USBG_BIT_TXBUSY  1
`define USBG_BIT_TXSHIFT 0
// Reset values
`define USBG_RST_ERR     3'h0
`define USBG_RST_CKSEL   4'h0
`define USBG_RST_DIV     8'hFF
`define USBG_RST_RXBUF   8'hFF
`define USBG_RST_TXBUF   8'hFF
// Timing counts
`define USBG_CKSEL_MAX   4'hB
`define USBG_START_TICKS 2'h2
`endif

// ### usbg_peer.sv
`timescale 1ns/1ns
`default_nettype none
// Shift engines on the line side, driven by the bench through tasks
module usbg_peer (
  input  wire logic       ref_clk_i,
  output logic            rx_done_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_par_o,
  output logic            rx_stop_o,
  output logic            tx_take_o,
  output logic            tx_fend_o
);
  // Quiet lines at time zero
  initial begin
    {rx_done_o, rx_data_o, rx_par_o, rx_stop_o, tx_take_o, tx_fend_o} = '0;
  end
  // One finished frame; lines flip after it so stale values never match
  task automatic rx_word(input logic [7:0] d, input logic p, input logic s);
    @(posedge ref_clk_i);
    rx_done_o <= 1'b1;
    rx_data_o <= d;
    rx_par_o  <= p;
    rx_stop_o <= s;
    @(posedge ref_clk_i);
    rx_done_o <= 1'b0;
    rx_data_o <= ~d;
    rx_par_o  <= ~p;
    rx_stop_o <= ~s;
  endtask
  // Shifter takes a word and/or ends a frame
  task automatic tx_event(input logic take, input logic fend);
    @(posedge ref_clk_i);
    tx_take_o <= take;
    tx_fend_o <= fend;
    @(posedge ref_clk_i);
    tx_take_o <= 1'b0;
    tx_fend_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### usbg_pkg.sv
package usbg_pkg;
  // Parity handling chosen by the mode register elsewhere
  typedef enum logic [1:0] {
    USBG_PAR_NONE,
    USBG_PAR_ZERO,
    USBG_PAR_ODD,
    USBG_PAR_EVEN
  } usbg_parity_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]  rdata;
    logic        pe;
    logic        fe;
    logic        ove;
    logic [7:0]  rxbuf;
    logic        rx_unread;
    logic [7:0]  txbuf;
    logic        tx_busy;
    logic        tx_shift;
    logic [3:0]  cksel;
    logic [7:0]  div;
    logic [10:0] psc;
    logic [1:0]  start_cnt;
    logic [7:0]  div_cnt;
    logic        baud_tick;
    logic        bit_clk;
  } usbg_state_t;
endpackage

// ### usbg_top.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "usbg_map.svh"

// Notes on behaviour
// - Error status register: bits 2..0 parity, framing, overrun; upper bits zero.
// - Received parity bit disagreeing with computed parity sets the parity flag.
// - Reception completing without a valid stop bit sets the framing flag.
// - Only the first stop bit position is checked for framing.
// - Completion while the previous word is unread sets the overrun flag.
// - On overrun the new word is dropped, receive buffer unchanged.
// - Error flags clear on status read, and while power and receive are off.
// - Parity flag behaviour depends on the selected parity mode.
// - Buffer-occupied flag sets on buffer write, clears on move or disable.
// - Shifting flag sets on move, clears at frame end with no next word.
// - Next word written after the move goes out with no gap.
// - Clock select n picks peripheral clock over 2^n, n up to 11.
// - Divider k from 8 to 255 divides base clock by k.
// - Bit rate is the divider output divided by a further 2.
// - Rewriting an unchanged select or divider value disturbs nothing.
// - Reset values: divider FFH, clock select 00H.
// - Power off stops the clock and resets status and receive buffer.
// - Zero-parity reception never checks parity, so no parity error.
// - Divider output becomes active on the third base clock after power-on.
module usbg_top (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  input  wire logic [15:0]           addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  input  wire logic                  unit_power_enable_i,
  input  wire logic                  transmit_enable_i,
  input  wire logic                  receive_enable_i,
  input  wire usbg_pkg::usbg_parity_t parity_mode_i,
  input  wire logic                  char_len8_i,
  input  wire logic                  rx_done_i,
  input  wire logic [7:0]            rx_data_i,
  input  wire logic                  rx_parity_bit_i,
  input  wire logic                  rx_stop_bit_i,
  input  wire logic                  tx_take_i,
  input  wire logic                  tx_frame_end_i,
  output logic      [7:0]            transmit_buffer_o,
  output logic      [7:0]            receive_buffer_o,
  output logic                       tx_buffer_occupied_o,
  output logic                       tx_shifting_o,
  output logic                       baud_tick_o,
  output logic                       bit_clk_o
);
  import usbg_pkg::*;

  usbg_state_t st;
  usbg_state_t next_st;

  // Mask of prescaler bits that must all be ones for a base clock pulse
  function automatic logic [10:0] psc_mask(input logic [3:0] sel);
    logic [3:0] n;
    n = (sel > `USBG_CKSEL_MAX) ? `USBG_CKSEL_MAX : sel;
    psc_mask = 11'((12'h001 << n) - 12'h001);
  endfunction

  // Parity the peer should have sent for the received character
  function automatic logic want_parity(input logic [7:0] d, input logic len8,
                                       input logic odd);
    logic p;
    p = len8 ? ^d : ^d[6:0];
    want_parity = odd ? ~p : p;
  endfunction

  logic wr_txbuf;
  logic wr_cksel;
  logic wr_div;
  logic rd_err;
  logic rd_rxbuf;
  logic base_tick;
  logic rx_off;
  logic tx_off;
  logic par_bad;

  // Register port decode
  always_comb begin
    wr_txbuf = 1'b0;
    wr_cksel = 1'b0;
    wr_div   = 1'b0;
    rd_err   = 1'b0;
    rd_rxbuf = 1'b0;
    if (addr_i == `USBG_OFS_TXBUF) begin
      wr_txbuf = wr_i;
    end else if (addr_i == `USBG_OFS_CKSEL) begin
      wr_cksel = wr_i;
    end else if (addr_i == `USBG_OFS_DIV) begin
      wr_div = wr_i;
    end else if (addr_i == `USBG_OFS_ERR) begin
      rd_err = rd_i;
    end else if (addr_i == `USBG_OFS_RXBUF) begin
      rd_rxbuf = rd_i;
    end
  end

  // Qualifiers shared by the flag logic
  assign rx_off    = ~unit_power_enable_i & ~receive_enable_i;
  assign tx_off    = ~unit_power_enable_i | ~transmit_enable_i;
  assign base_tick = unit_power_enable_i &&
                     ((st.psc & psc_mask(st.cksel)) == psc_mask(st.cksel));
  // Parity is only judged in odd or even mode; zero parity is never checked
  assign par_bad   = parity_mode_i[1] &&
                     (rx_parity_bit_i != want_parity(rx_data_i, char_len8_i,
                                                     parity_mode_i == USBG_PAR_ODD));

  // Next state
  always_comb begin
    next_st = st;
    next_st.baud_tick = 1'b0;

    // Read data stands for exactly one cycle after the strobe
    next_st.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == `USBG_OFS_ERR) begin
        next_st.rdata = {5'h00, st.pe, st.fe, st.ove};
      end else if (addr_i == `USBG_OFS_TXSTAT) begin
        next_st.rdata = {6'h00, st.tx_busy, st.tx_shift};
      end else if (addr_i == `USBG_OFS_CKSEL) begin
        next_st.rdata = {4'h0, st.cksel};
      end else if (addr_i == `USBG_OFS_DIV) begin
        next_st.rdata = st.div;
      end else if (addr_i == `USBG_OFS_RXBUF) begin
        next_st.rdata = st.rxbuf;
      end else if (addr_i == `USBG_OFS_TXBUF) begin
        next_st.rdata = st.txbuf;
      end
    end

    // Configuration; storing the same value leaves the counters alone
    if (wr_cksel) begin
      next_st.cksel = wdata_i[3:0];
    end
    if (wr_div) begin
      next_st.div = wdata_i;
    end

    // Receive error flags: read clears, a new event in the same cycle wins
    if (rd_err || rx_off) begin
      next_st.pe  = 1'b0;
      next_st.fe  = 1'b0;
      next_st.ove = 1'b0;
    end
    if (rd_rxbuf) begin
      next_st.rx_unread = 1'b0;
    end
    if (rx_done_i && unit_power_enable_i && receive_enable_i) begin
      if (par_bad) begin
        next_st.pe = 1'b1;
      end
      // Only the first stop bit is sampled by the shift engine
      if (!rx_stop_bit_i) begin
        next_st.fe = 1'b1;
      end
      if (st.rx_unread && !rd_rxbuf) begin
        next_st.ove = 1'b1;
      end else begin
        next_st.rxbuf     = rx_data_i;
        next_st.rx_unread = 1'b1;
      end
    end

    // Transmit status; a write while occupied simply overwrites the buffer
    if (wr_txbuf) begin
      next_st.txbuf = wdata_i;
    end
    if (tx_off) begin
      next_st.tx_busy  = 1'b0;
      next_st.tx_shift = 1'b0;
    end else begin
      if (tx_frame_end_i) begin
        next_st.tx_shift = 1'b0;
      end
      // A take in the same cycle as frame end keeps the line busy
      if (tx_take_i && st.tx_busy) begin
        next_st.tx_busy  = 1'b0;
        next_st.tx_shift = 1'b1;
      end
      if (wr_txbuf) begin
        next_st.tx_busy = 1'b1;
      end
    end

    // Baud generator: prescaler, start delay, divider, bit clock
    if (unit_power_enable_i) begin
      next_st.psc = st.psc + 11'h001;
      if (base_tick) begin
        if (st.start_cnt != `USBG_START_TICKS) begin
          next_st.start_cnt = st.start_cnt + 2'h1;
        end else if (st.div_cnt >= st.div - 8'h01) begin
          next_st.div_cnt   = 8'h00;
          next_st.baud_tick = 1'b1;
          next_st.bit_clk   = ~st.bit_clk;
        end else begin
          next_st.div_cnt = st.div_cnt + 8'h01;
        end
      end
    end

    // Power off halts and clears the unit; configuration is kept
    if (!unit_power_enable_i) begin
      next_st.pe        = 1'b0;
      next_st.fe        = 1'b0;
      next_st.ove       = 1'b0;
      next_st.rxbuf     = `USBG_RST_RXBUF;
      next_st.rx_unread = 1'b0;
      next_st.psc       = 11'h000;
      next_st.start_cnt = 2'h0;
      next_st.div_cnt   = 8'h00;
      next_st.bit_clk   = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st           <= '0;
      st.rxbuf     <= `USBG_RST_RXBUF;
      st.txbuf     <= `USBG_RST_TXBUF;
      st.cksel     <= `USBG_RST_CKSEL;
      st.div       <= `USBG_RST_DIV;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign rdata_o              = st.rdata;
  assign transmit_buffer_o    = st.txbuf;
  assign receive_buffer_o     = st.rxbuf;
  assign tx_buffer_occupied_o = st.tx_busy;
  assign tx_shifting_o        = st.tx_shift;
  assign baud_tick_o          = st.baud_tick;
  assign bit_clk_o            = st.bit_clk;

  // Checks kept beside the logic
  a_err_upper_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rd_i && addr_i == `USBG_OFS_ERR) |=> (rdata_o[7:3] == 5'h00))
    else $error("error status upper bits not zero");

  a_err_read_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rd_i && addr_i == `USBG_OFS_ERR && !rx_done_i) |=> (!st.pe && !st.fe && !st.ove))
    else $error("error flags survived a status read");

  a_frame_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rx_done_i && !rx_stop_bit_i && unit_power_enable_i && receive_enable_i) |=> st.fe)
    else $error("framing flag not set");

  a_zero_par_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rx_done_i && !parity_mode_i[1] && !st.pe) |=> !st.pe)
    else $error("parity flag set without parity check");

  a_overrun_keep: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rx_done_i && st.rx_unread && !rd_rxbuf && unit_power_enable_i && receive_enable_i)
      |=> (st.ove && st.rxbuf == $past(st.rxbuf)))
    else $error("overrun did not keep the buffer");

  a_txbuf_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_txbuf && !tx_off) |=> (tx_buffer_occupied_o && transmit_buffer_o == $past(wdata_i)))
    else $error("buffer flag not set by write");

  a_tx_off_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    tx_off |=> (!tx_buffer_occupied_o && !tx_shifting_o))
    else $error("transmit status not cleared when disabled");

  a_tick_spacing: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (baud_tick_o && st.div >= 8'h08) |=> !baud_tick_o [*7])
    else $error("divider pulses closer than eight cycles");

  a_bitclk_toggle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (baud_tick_o && $past(unit_power_enable_i)) |-> (bit_clk_o != $past(bit_clk_o)))
    else $error("bit clock did not toggle on divider pulse");

  a_start_delay: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(unit_power_enable_i) |-> !baud_tick_o [*3])
    else $error("divider output active too early");

  // Receive side: each event lands in the flags or buffer one cycle later
  a_par_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rx_done_i && unit_power_enable_i && receive_enable_i && par_bad) |=> st.pe)
    else $error("parity flag not set");

  a_first_stop: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rx_done_i && rx_stop_bit_i && !st.fe) |=> !st.fe)
    else $error("framing flag set with a good first stop bit");

  a_load_new: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rx_done_i && !st.rx_unread && unit_power_enable_i && receive_enable_i)
      |=> (receive_buffer_o == $past(rx_data_i)))
    else $error("received word not loaded");

  a_rx_off_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rx_off |=> (!st.pe && !st.fe && !st.ove))
    else $error("error flags survived receive disable");

  a_par_none: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rx_done_i && parity_mode_i == USBG_PAR_NONE && !st.pe) |=> !st.pe)
    else $error("parity flag set with parity off");

  // Transmit side: buffer to shifter handover
  a_take_move: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tx_take_i && st.tx_busy && !tx_off && !wr_txbuf)
      |=> (!tx_buffer_occupied_o && tx_shifting_o))
    else $error("buffer move not reflected in status");

  a_frame_end: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tx_frame_end_i && !tx_take_i) |=> !tx_shifting_o)
    else $error("shifting flag kept after last frame");

  a_no_gap: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tx_frame_end_i && tx_take_i && st.tx_busy && !tx_off) |=> tx_shifting_o)
    else $error("gap between back to back frames");

  // Baud chain
  a_base_rate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (base_tick && st.cksel == 4'h1 && !wr_cksel) |=> !base_tick)
    else $error("base clock faster than selected");

  a_tick_on_base: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    baud_tick_o |-> $past(base_tick))
    else $error("divider pulse without a base clock");

  a_div_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_div |=> (st.div == $past(wdata_i)))
    else $error("divider write lost");

  // Values seen on leaving reset and after power off
  a_reset_vals: assert property (@(posedge ref_clk_i)
    $fell(reset_i) |-> (st.cksel == `USBG_RST_CKSEL && st.div == `USBG_RST_DIV))
    else $error("configuration reset values wrong");

  a_power_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !unit_power_enable_i
      |=> (receive_buffer_o == `USBG_RST_RXBUF && !st.rx_unread && !bit_clk_o))
    else $error("power off did not clear the unit");

  // Read port data
  a_err_rd_data: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (rd_i && addr_i == `USBG_OFS_ERR)
      |=> (rdata_o[2] == $past(st.pe) && rdata_o[1] == $past(st.fe)
           && rdata_o[0] == $past(st.ove)))
    else $error("error status read data wrong");

  a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !rd_i |=> (rdata_o == 8'h00))
    else $error("read data outside the read cycle");

endmodule
`default_nettype wire

// ### usbg_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "usbg_map.svh"
module usbg_top_bench;
  import usbg_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] addr = '0;
  logic [7:0] wdata = '0, rdata, txb, rxb, b;
  logic wr = 1'b0, rd = 1'b0, pwr = 1'b0, txe = 1'b0, rxe = 1'b0;
  logic rdn, rxd, rxp, rxs, tk, fe, occ, sh, tick, bclk, cl8 = 1'b1;
  logic [7:0] rbo;
  usbg_parity_t pm = USBG_PAR_NONE;
  int miscompares = 0, n_compared = 0, g;
  // 250 MHz
  always #2 ref_clk_i = ~ref_clk_i;
  usbg_peer i_usbg_peer (.ref_clk_i(ref_clk_i), .rx_done_o(rdn), .rx_data_o(rxb),
    .rx_par_o(rxp), .rx_stop_o(rxs), .tx_take_o(tk), .tx_fend_o(fe));
  usbg_top i_usbg_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .unit_power_enable_i(pwr),
    .transmit_enable_i(txe), .receive_enable_i(rxe), .parity_mode_i(pm),
    .char_len8_i(cl8), .rx_done_i(rdn), .rx_data_i(rxb), .rx_parity_bit_i(rxp),
    .rx_stop_bit_i(rxs), .tx_take_i(tk), .tx_frame_end_i(fe), .transmit_buffer_o(txb),
    .receive_buffer_o(rbo), .tx_buffer_occupied_o(occ), .tx_shifting_o(sh),
    .baud_tick_o(tick), .bit_clk_o(bclk));
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  // Cycles up to the next baud tick; a stuck divider ends the run
  task automatic tick_gap();
    g = 0;
    do begin
      @(posedge ref_clk_i);
      #1 g++;
      if (g > 5000) begin
        miscompares++;
        complete_run();
      end
    end while (tick !== 1'b1);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd_chk(`USBG_OFS_ERR, 8'h00, "rx_error_status");
    rd_chk(`USBG_OFS_TXSTAT, 8'h00, "tx_status");
    rd_chk(`USBG_OFS_CKSEL, 8'h00, "base_clock_select");
    rd_chk(`USBG_OFS_DIV, 8'hFF, "baud_divider");
    rd_chk(16'hFF00, 8'h00, "unmapped");
    wr_reg(`USBG_OFS_ERR, 8'hFF);
    rd_chk(`USBG_OFS_ERR, 8'h00, "rx_error_status");
    // Select and divider set while powered down
    wr_reg(`USBG_OFS_CKSEL, 8'h01);
    wr_reg(`USBG_OFS_DIV, 8'h08);
    rd_chk(`USBG_OFS_CKSEL, 8'h01, "base_clock_select");
    pwr <= 1'b1;
    tick_gap();
    b = {7'h0, bclk};
    tick_gap();
    chk("tick period", 8'h10, g[7:0]);
    chk("bit_clk", ~b, {7'h7F, bclk});
    wr_reg(`USBG_OFS_DIV, 8'h08);
    tick_gap();
    tick_gap();
    chk("tick period", 8'h10, g[7:0]);
    // Bad parity and missing stop bit, then an overrun
    rxe <= 1'b1;
    pm  <= USBG_PAR_EVEN;
    i_usbg_peer.rx_word(8'h01, 1'b0, 1'b0);
    #1 chk("receive_buffer", 8'h01, rbo);
    rd_chk(`USBG_OFS_ERR, 8'h06, "rx_error_status");
    rd_chk(`USBG_OFS_ERR, 8'h00, "rx_error_status");
    i_usbg_peer.rx_word(8'h02, 1'b1, 1'b1);
    rd_chk(`USBG_OFS_ERR, 8'h01, "rx_error_status");
    rd_chk(`USBG_OFS_RXBUF, 8'h01, "receive_buffer");
    chk("receive_buffer", 8'h01, rbo);
    // Parity bit one on data 01 is wrong only for odd parity
    for (int m = 0; m < 4; m++) begin
      pm <= usbg_parity_t'(m);
      i_usbg_peer.rx_word(8'h01, 1'b1, 1'b1);
      rd_chk(`USBG_OFS_ERR, (m == 2) ? 8'h04 : 8'h00, "rx_error_status");
      rd_chk(`USBG_OFS_RXBUF, 8'h01, "receive_buffer");
    end
    // Seven-bit characters judge parity over bits 6..0 only
    cl8 <= 1'b0;
    pm  <= USBG_PAR_EVEN;
    i_usbg_peer.rx_word(8'h81, 1'b1, 1'b1);
    rd_chk(`USBG_OFS_ERR, 8'h00, "rx_error_status");
    rd_chk(`USBG_OFS_RXBUF, 8'h81, "receive_buffer");
    cl8 <= 1'b1;
    i_usbg_peer.rx_word(8'h33, 1'b0, 1'b0);
    rxe <= 1'b0;
    pwr <= 1'b0;
    rd_chk(`USBG_OFS_ERR, 8'h00, "rx_error_status");
    rd_chk(`USBG_OFS_RXBUF, 8'hFF, "receive_buffer");
    // Transmit: write, move, refill without gap, frame ends
    pwr <= 1'b1;
    txe <= 1'b1;
    wr_reg(`USBG_OFS_TXBUF, 8'hA5);
    #1 chk("tx_status", 8'h02, {6'h0, occ, sh});
    chk("transmit_buffer", 8'hA5, txb);
    i_usbg_peer.tx_event(1'b1, 1'b0);
    #1 chk("tx_status", 8'h01, {6'h0, occ, sh});
    wr_reg(`USBG_OFS_TXBUF, 8'h5A);
    i_usbg_peer.tx_event(1'b1, 1'b1);
    rd_chk(`USBG_OFS_TXSTAT, 8'h01, "tx_status");
    i_usbg_peer.tx_event(1'b0, 1'b1);
    #1 chk("tx_status", 8'h00, {6'h0, occ, sh});
    wr_reg(`USBG_OFS_TXBUF, 8'h3C);
    txe <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk("tx_status", 8'h00, {6'h0, occ, sh});
    complete_run();
  end
endmodule
`default_nettype wire
